//--- verilog/ecpc_regs.vh
// constants for the charge port controller: timing, frame layout, defaults
`ifndef ECPC_REGS_VH
`define ECPC_REGS_VH

// system clock in kHz (200 MHz)
`define ECPC_CLK_KHZ         200000
// periodic power message interval in ms (4 Hz)
`define ECPC_MSG_PERIOD_MS   250
// message interval in clock cycles: 250 ms at 200000 kHz, 50,000,000;
// sized here so it meets the 26-bit counter without silent truncation
`define ECPC_MSG_CYCLES      26'h2faf080
// can link bit rate in kbit/s
`define ECPC_CAN_KBPS        250
// can bit time in clock cycles: 200000 kHz over 250 kbit/s, 800
`define ECPC_CAN_BIT_CYCLES  10'h320
// can identifier of the power message, 45 decimal, extended format
`define ECPC_CAN_ID          29'h0000002d
`define ECPC_CAN_ID_W        29
`define ECPC_CAN_EXT         1'b1
// data length of the power message in bytes
`define ECPC_CAN_DLC         4'h2
// mains voltage assumed when no measurement is connected (240 V)
`define ECPC_VOLT_DEFAULT    10'h0f0
`define ECPC_VOLT_W          10
`define ECPC_AMP_W           8
`define ECPC_PWR_W           16
`define ECPC_PWR_MAX         16'hffff

`endif

//--- verilog/ecpc_controller.v
// vehicle side ac charge port controller with periodic can power report
`timescale 1ns/10ps
// Functional notes
// - on cable plug-in the charge enable output goes low.
// - after plug-in the pilot line reports the vehicle ready for charge.
// - led flashes from plug-in; with a can link it stops when charged.
// - on completion the pilot line says charging is finished.
// - the release button turns charge enable off at once, whatever else.
// - while charging one can message, id 45, is sent four times a second.
// - message bytes 0-1 hold available ac watts, 16 bits, no losses.
// - can defaults to 250 kbit/s with extended 29-bit ids; peers match.
// - reported power uses the measured mains voltage so it tracks mains.
// - with no mains measurement connected a fixed 240 V is used.
// - the remote led output follows the on-board led exactly.

`include "ecpc_regs.vh"

module ecpc_controller #(
    parameter [25:0] P_MSG_CYCLES = `ECPC_MSG_CYCLES
) (
    input  wire                      i_clk_sys,
    input  wire                      i_rst_b,
    input  wire                      i_cable_plugged,
    input  wire                      i_release_button,
    input  wire                      i_charge_done,
    input  wire                      i_can_link_present,
    input  wire                      i_volt_connected,
    input  wire [`ECPC_VOLT_W-1:0]   i_mains_voltage_sense,
    input  wire [`ECPC_AMP_W-1:0]    i_current_limit,
    input  wire                      i_lsb_first,
    input  wire                      i_msg_ready,
    output wire                      o_charge_en_b,
    output reg                       o_pilot_ready,
    output reg                       o_pilot_done,
    output reg                       o_led,
    output wire                      o_remote_led,
    output wire                      o_msg_valid,
    output reg  [`ECPC_CAN_ID_W-1:0] o_msg_id,
    output reg                       o_msg_ext,
    output reg  [3:0]                o_msg_dlc,
    output reg  [7:0]                o_msg_byte0,
    output reg  [7:0]                o_msg_byte1,
    output reg  [9:0]                o_can_bit_cycles
);

    localparam [25:0] L_TICK_LAST = P_MSG_CYCLES - 26'h0000001;

    // charge sequence states
    localparam [1:0]  ST_IDLE     = 2'h0;
    localparam [1:0]  ST_CHARGE   = 2'h1;
    localparam [1:0]  ST_DONE     = 2'h2;
    localparam [1:0]  ST_RELEASE  = 2'h3;

    reg  [1:0]                state;
    reg  [1:0]                next_state;
    reg                       charge_en_b;
    reg  [25:0]               tick_cnt;
    reg                       tick;
    reg                       msg_pending;
    reg  [`ECPC_PWR_W-1:0]    power;
    wire [`ECPC_VOLT_W-1:0]   volts;
    wire [17:0]               product;
    wire                      charging;

    // sequence state machine; release wins over every other event
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (i_cable_plugged && !i_release_button) begin
                    next_state = ST_CHARGE;
                end
            end
            ST_CHARGE: begin
                if (i_release_button) begin
                    next_state = ST_RELEASE;
                end else if (!i_cable_plugged) begin
                    next_state = ST_IDLE;
                end else if (i_charge_done) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (i_release_button) begin
                    next_state = ST_RELEASE;
                end else if (!i_cable_plugged) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RELEASE: begin
                // wait for the cable to leave so letting go of the button cannot restart
                if (!i_cable_plugged) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign charging = (state == ST_CHARGE);

    // charge enable is low only while charging; registered from next state
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            charge_en_b <= 1'b1;
        end else begin
            charge_en_b <= (next_state != ST_CHARGE);
        end
    end

    // the button path bypasses the flop so the charger stops with no delay
    assign o_charge_en_b = charge_en_b | i_release_button;

    // pilot line indications toward the supply equipment
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_pilot_ready <= 1'b0;
            o_pilot_done  <= 1'b0;
        end else begin
            o_pilot_ready <= (next_state == ST_CHARGE);
            o_pilot_done  <= (next_state == ST_DONE);
        end
    end

    // quarter second tick shared by the message rate and the led blink;
    // held at zero in idle and release so the first message is a full period in
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            tick_cnt <= 26'h0000000;
            tick     <= 1'b0;
        end else if (state == ST_IDLE ||
                     state == ST_RELEASE) begin
            tick_cnt <= 26'h0000000;
            tick     <= 1'b0;
        end else if (tick_cnt == L_TICK_LAST) begin
            tick_cnt <= 26'h0000000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 26'h0000001;
            tick     <= 1'b0;
        end
    end

    // led: flash while charging, steady on once done if a can link exists
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_led <= 1'b0;
        end else if (state == ST_IDLE ||
                     state == ST_RELEASE) begin
            o_led <= 1'b0;
        end else if (state == ST_DONE && i_can_link_present) begin
            o_led <= 1'b1;
        end else if (tick) begin
            o_led <= ~o_led;
        end
    end

    // same flop drives both, so the two can never disagree
    assign o_remote_led = o_led;

    // available power from measured or default mains voltage
    assign volts   = i_volt_connected ? i_mains_voltage_sense
                                      : `ECPC_VOLT_DEFAULT;
    assign product = volts * i_current_limit;

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            power <= 16'h0000;
        end else if (product[17:16] != 2'h0) begin
            power <= `ECPC_PWR_MAX;
        end else begin
            power <= product[15:0];
        end
    end

    // message request; data is frozen while a request waits for the
    // controller, and a tick that finds one pending is dropped, which
    // keeps the rate at most 4 Hz if the bus is congested
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            msg_pending <= 1'b0;
            o_msg_byte0 <= 8'h00;
            o_msg_byte1 <= 8'h00;
        end else if (msg_pending) begin
            if (i_msg_ready || !charging) begin
                msg_pending <= 1'b0;
            end
        end else if (tick && charging) begin
            msg_pending <= 1'b1;
            if (i_lsb_first) begin
                o_msg_byte0 <= power[7:0];
                o_msg_byte1 <= power[15:8];
            end else begin
                o_msg_byte0 <= power[15:8];
                o_msg_byte1 <= power[7:0];
            end
        end
    end

    // a request is withdrawn at once when charging stops
    assign o_msg_valid = msg_pending & charging;

    // fixed frame header and link bit timing for the can controller
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_msg_id         <= 29'h00000000;
            o_msg_ext        <= 1'b0;
            o_msg_dlc        <= 4'h0;
            o_can_bit_cycles <= 10'h000;
        end else begin
            o_msg_id         <= `ECPC_CAN_ID;
            o_msg_ext        <= `ECPC_CAN_EXT;
            o_msg_dlc        <= `ECPC_CAN_DLC;
            o_can_bit_cycles <= `ECPC_CAN_BIT_CYCLES;
        end
    end

endmodule

//--- dv/ecpc_can_model.sv
// partner model: can controller taking power messages after a delay
`timescale 1ns/10ps
module ecpc_can_model (
    input  wire        i_clk_sys,
    input  wire        i_valid,
    input  wire        i_ext,
    input  wire [9:0]  i_bit_cycles,
    input  wire [7:0]  i_byte0,
    input  wire [7:0]  i_byte1,
    input  wire [3:0]  i_delay,
    output reg         o_ready = 1'b0,
    output reg  [15:0] o_data = 16'h0,
    output reg  [7:0]  o_hits = 8'h0,
    output reg         o_fmt_ok = 1'b0
);
    reg [3:0] wait_cnt = 4'h0;
    // ready only answers a standing request, never offered ahead of it
    always @(posedge i_clk_sys) begin
        if (i_valid && o_ready) begin
            o_hits <= o_hits + 8'h1;
            o_data <= {i_byte0, i_byte1};
            o_fmt_ok <= i_ext && (i_bit_cycles == 10'h320);
        end
        if (!i_valid || o_ready) begin
            o_ready <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (wait_cnt == i_delay)
            o_ready <= 1'b1;
        else
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule

//--- dv/ecpc_checker.sv
// port assertions for the charge port controller
`timescale 1ns/10ps
module ecpc_checker (
    input wire        i_clk_sys,
    input wire        i_rst_b,
    input wire        i_release_button,
    input wire        i_msg_ready,
    input wire        o_charge_en_b,
    input wire        o_pilot_ready,
    input wire        o_pilot_done,
    input wire        o_led,
    input wire        o_remote_led,
    input wire        o_msg_valid,
    input wire [28:0] o_msg_id,
    input wire        o_msg_ext,
    input wire [3:0]  o_msg_dlc,
    input wire [9:0]  o_can_bit_cycles
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    a_release_off: assert property (
        i_release_button |-> o_charge_en_b)
        else $error("enable on during release");
    a_ready_enable: assert property (
        o_pilot_ready && !i_release_button |-> !o_charge_en_b)
        else $error("ready without enable");
    a_done_pilot: assert property (
        $rose(o_pilot_done) |-> o_charge_en_b && !o_pilot_ready)
        else $error("done without stop");
    a_led_mirror: assert property (
        o_remote_led == o_led)
        else $error("remote led differs");
    a_msg_header: assert property (
        o_msg_valid |-> o_msg_id == 29'h0000002d && o_msg_ext &&
            o_msg_dlc == 4'h2)
        else $error("bad message header");
    a_msg_charging: assert property (
        o_msg_valid |-> o_pilot_ready)
        else $error("message outside charging");
    a_accept_drop: assert property (
        o_msg_valid && i_msg_ready |=> !o_msg_valid)
        else $error("message repeated");
    a_bit_rate: assert property (
        $past(i_rst_b) |-> o_can_bit_cycles == 10'h320)
        else $error("bad bit time");
endmodule
bind ecpc_controller ecpc_checker u_ecpc_checker (
    .i_clk_sys        (i_clk_sys),
    .i_rst_b          (i_rst_b),
    .i_release_button (i_release_button),
    .i_msg_ready      (i_msg_ready),
    .o_charge_en_b    (o_charge_en_b),
    .o_pilot_ready    (o_pilot_ready),
    .o_pilot_done     (o_pilot_done),
    .o_led            (o_led),
    .o_remote_led     (o_remote_led),
    .o_msg_valid      (o_msg_valid),
    .o_msg_id         (o_msg_id),
    .o_msg_ext        (o_msg_ext),
    .o_msg_dlc        (o_msg_dlc),
    .o_can_bit_cycles (o_can_bit_cycles)
);

//--- dv/tb_top.sv
// self-checking bench for the charge port controller
`timescale 1ns/10ps
module tb_top;
    localparam P = 20; // short tick keeps the run brief
    reg         clk = 0, rst_b = 0, plug = 0, rel = 0, done = 0;
    reg         link = 1, vc = 1, lsb = 0;
    reg  [9:0]  volt = 10'h0e6;
    reg  [7:0]  amp = 8'h20;
    reg  [3:0]  dly = 4'h0;
    wire        en_b, rdy, pdone, led, rled, vld, ext, mrdy, fmt;
    wire [28:0] id;
    wire [3:0]  dlc;
    wire [7:0]  b0, b1, hits;
    wire [9:0]  bc;
    wire [15:0] got;
    integer     bad_count = 0, compares = 0, k, t0;
    initial forever #2.5 clk = ~clk;
    ecpc_controller #(.P_MSG_CYCLES(26'd20)) u_ecpc_controller (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_cable_plugged(plug),
        .i_release_button(rel), .i_charge_done(done),
        .i_can_link_present(link), .i_volt_connected(vc),
        .i_mains_voltage_sense(volt), .i_current_limit(amp),
        .i_lsb_first(lsb), .i_msg_ready(mrdy), .o_charge_en_b(en_b),
        .o_pilot_ready(rdy), .o_pilot_done(pdone), .o_led(led),
        .o_remote_led(rled), .o_msg_valid(vld), .o_msg_id(id),
        .o_msg_ext(ext), .o_msg_dlc(dlc), .o_msg_byte0(b0),
        .o_msg_byte1(b1), .o_can_bit_cycles(bc));
    ecpc_can_model u_ecpc_can_model (.i_clk_sys(clk), .i_valid(vld),
        .i_ext(ext), .i_bit_cycles(bc), .i_byte0(b0), .i_byte1(b1),
        .i_delay(dly), .o_ready(mrdy), .o_data(got), .o_hits(hits),
        .o_fmt_ok(fmt));
    task cyc(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        compares = compares + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // bounded wait for the partner to take one more message
    task wmsg;
        k = hits;
        repeat (4 * P) if (hits == k) cyc(1);
    endtask
    task t_plug;
        plug = 1;
        cyc(1);
        chk("enable", 16'h0, en_b);
        chk("ready", 16'h1, rdy);
        dly = 4'h3;
        wmsg;
        chk("power", 16'h1cc0, got);
        chk("format", 16'h1, fmt);
        k = led;
        cyc(P);
        chk("flash", 16'h0001, {15'h0000, led !== k[0]});
        $display("plug test ended");
    endtask
    task t_rate;
        dly = 4'h0;
        wmsg;
        t0 = $time;
        wmsg;
        chk("gap ns", 16'h0064, $time - t0);
        $display("rate test ended");
    endtask
    // first message after a change may still carry the old power
    task t_volt;
        vc = 0;
        amp = 8'h10;
        lsb = 1;
        wmsg;
        wmsg;
        chk("default", 16'h000f, got);
        vc = 1;
        volt = 10'h3ff;
        amp = 8'hff;
        lsb = 0;
        wmsg;
        wmsg;
        chk("saturate", 16'hffff, got);
        $display("power test ended");
    endtask
    task t_done;
        done = 1;
        cyc(1);
        chk("done", 16'h1, pdone);
        chk("ready off", 16'h0, rdy);
        k = hits;
        cyc(P + 2);
        chk("led on", 16'h1, led);
        cyc(P);
        chk("led held", 16'h1, led);
        chk("no msg", k, hits);
        // without a can link the led keeps flashing after completion
        link = 0;
        k = led;
        cyc(P);
        chk("flash no link", 16'h0001, {15'h0000, led !== k[0]});
        link = 1;
        plug = 0;
        done = 0;
        cyc(2);
        $display("done test ended");
    endtask
    task t_release;
        plug = 1;
        cyc(2);
        rel = 1;
        #1;
        chk("release", 16'h1, en_b);
        cyc(1);
        rel = 0;
        cyc(1);
        chk("held off", 16'h1, en_b);
        plug = 0;
        cyc(2);
        $display("release test ended");
    endtask
    task conclude;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        cyc(8);
        rst_b = 1;
        cyc(1);
        t_plug;
        t_rate;
        t_volt;
        t_done;
        t_release;
        conclude;
    end
    // tests need a few hundred cycles; this allows over ten times that
    initial begin
        #20000;
        bad_count = bad_count + 1;
        conclude;
    end
endmodule
